// ===== verilog/adsc_pkg.sv
// Constants shared by the converter sequencing controller
package adsc_pkg;
	// Device register map, reached over the device's own register port
	localparam logic [2:0] DEV_MODE   = 3'h0;
	localparam logic [2:0] DEV_CHAN   = 3'h1;
	localparam logic [2:0] DEV_PCFG   = 3'h2;
	localparam logic [2:0] DEV_P2DIR  = 3'h3;
	localparam logic [2:0] DEV_P2LAT  = 3'h4;
	localparam logic [2:0] DEV_RES_LO = 3'h5;
	localparam logic [2:0] DEV_RES_HI = 3'h6;
	localparam logic [2:0] DEV_IRQF   = 3'h7;
	// Mode register fields
	localparam int MODE_START_BIT = 7;
	localparam int MODE_CE_BIT    = 0;
	localparam int MODE_TIME_LSB  = 1;
	localparam int MODE_TIME_W    = 5;
	// Channel and port configuration codes barred on the reduced-pin variant
	localparam logic [2:0] CHAN_BAD_A = 3'h6;
	localparam logic [2:0] CHAN_BAD_B = 3'h7;
	localparam logic [3:0] PCFG_BAD_A = 4'h7;
	localparam logic [3:0] PCFG_BAD_B = 4'h8;
	localparam logic [7:0] P2_HIGH_PINS = 8'hC0;
	// Controller register indices
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_CFG    = 4'h1;
	localparam logic [3:0] REG_PORT   = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_RESULT = 4'h4;
	localparam logic [3:0] REG_IRQ_ST = 4'h5;
	localparam logic [3:0] REG_IRQ_MK = 4'h6;
	// Configuration register fields
	localparam int CFG_CHAN_LSB = 0;
	localparam int CFG_PCFG_LSB = 3;
	localparam int CFG_TIME_LSB = 7;
	localparam int CFG_REDUCED  = 12;
	localparam int CFG_SKIP_CE  = 13;
	// Interrupt bits
	localparam int IRQ_RESULT  = 0;
	localparam int IRQ_CFG_ERR = 1;
	localparam int IRQ_DROPPED = 2;
	localparam int IRQ_W       = 3;
	// Reset values
	localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
	localparam logic [15:0] PORT_RESET = 16'h0000;
	// Settling time from comparator enable to start
	localparam int CLK_NS     = 10;
	localparam int SETTLE_NS  = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [3:0] {
		S_IDLE, S_CLR, S_PCFG, S_DIR, S_LAT, S_ENA, S_CHAN,
		S_SETTLE, S_START, S_RUN, S_RDL, S_RDH, S_ACK, S_STOP
	} adsc_state_t;
endpackage

// ===== verilog/adsc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module adsc_sync #(
	parameter int W = 1
) (
	input  wire logic         clock, // System clock
	input  wire logic         rst,   // Asynchronous reset
	input  wire logic [W-1:0] d,     // Asynchronous input
	output logic      [W-1:0] q      // Synchronised output
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// ===== verilog/adsc_timer.sv
// Down counter that flags when a loaded interval has elapsed
`timescale 1ns/1ps
module adsc_timer #(
	parameter int W = 8
) (
	input  wire logic         clock, // System clock
	input  wire logic         rst,   // Asynchronous reset
	input  wire logic         load,  // Restart the interval
	input  wire logic [W-1:0] count, // Interval in cycles
	output logic              done   // High once the interval has run out
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			done  <= 1'b0;
		end else if (load) begin
			cnt_r <= count;
			done  <= 1'b0;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
			done  <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
		end
	end
endmodule

// ===== verilog/adsc_ctrl.sv
// Host-side sequencer that drives the converter through its register port
// Operation
// - Channel select writes always carry zero in bits 3 to 7.
// - Channel select writes wait out the device's wait cycle and are not issued while the peripheral clock is stopped.
// - On the reduced-pin variant, channel codes 110 and 111 are never written.
// - The selected channel's port 2 pin is made an input before conversion.
// - Port configuration writes wait out the wait cycle and are not issued while the peripheral clock is stopped.
// - On the reduced-pin variant, port configuration codes 0111 and 1000 are never written.
// - On the reduced-pin variant, port 2 pins 6 and 7 are inputs with their latch bits cleared.
// - At least 1 us passes between comparator enable and setting the start bit.
// - Comparator enable is written after port configuration and before channel selection.
// - When comparator enable is skipped, the first result after start is dropped.
// - Stopping clears start and comparator enable, and the completion flag is cleared before each restart.
// - A start within 1 us of enable, or with the comparator off, waits on the completion pin edge and its first result is dropped.
`timescale 1ns/1ps
module adsc_ctrl (
	input  wire logic        clock,       // 100 MHz system clock
	input  wire logic        rst,         // Asynchronous reset, active high
	input  wire logic [3:0]  addr,        // Register index
	input  wire logic [31:0] wdata,       // Write data
	input  wire logic        wr,          // Write strobe
	input  wire logic        rd,          // Read strobe
	output logic      [31:0] rdata,       // Read data, cycle after rd
	output logic             irq,         // Level interrupt
	output logic      [2:0]  dev_addr,    // Device register select
	output logic      [7:0]  dev_wdata,   // Device write data
	output logic             dev_we,      // Device write strobe
	output logic             dev_re,      // Device read strobe
	input  wire logic [7:0]  dev_rdata,   // Device read data, cycle after access
	input  wire logic        dev_wait,    // Device holds the current access
	input  wire logic        dev_done,    // Completion interrupt pin
	input  wire logic        pclk_stopped // Peripheral clock stopped pin
);
	adsc_pkg::adsc_state_t state_r, state_nxt;
	logic [31:0] cfg_r;
	logic [15:0] port_r;
	logic [9:0]  result_r;
	logic [7:0]  res_lo_r;
	localparam int IRQ_W_L = adsc_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] irq_st_r, irq_mk_r, irq_ev;
	logic        discard_r, go_r, acc_done_r, done_s, done_d_r, stop_s, stop_req_r;
	logic        start_cmd, stop_cmd, cfg_bad, timer_done, timer_load, done_edge;
	logic [2:0]  chan;
	logic [3:0]  pcfg;
	logic [4:0]  ctime;
	logic        reduced, skip_ce;
	logic [7:0]  chan_bit, acc_data;
	logic [2:0]  acc_addr;
	logic        acc_rd, acc_any;

	assign chan     = cfg_r[adsc_pkg::CFG_CHAN_LSB +: 3];
	assign pcfg     = cfg_r[adsc_pkg::CFG_PCFG_LSB +: 4];
	assign ctime    = cfg_r[adsc_pkg::CFG_TIME_LSB +: 5];
	assign reduced  = cfg_r[adsc_pkg::CFG_REDUCED];
	assign skip_ce  = cfg_r[adsc_pkg::CFG_SKIP_CE];
	assign chan_bit = 8'h01 << chan;
	assign start_cmd = wr && addr == adsc_pkg::REG_CTRL && wdata[0];
	assign stop_cmd  = wr && addr == adsc_pkg::REG_CTRL && wdata[1];
	assign cfg_bad = reduced && (chan == adsc_pkg::CHAN_BAD_A || chan == adsc_pkg::CHAN_BAD_B
		|| pcfg == adsc_pkg::PCFG_BAD_A || pcfg == adsc_pkg::PCFG_BAD_B);
	assign done_edge = done_s && !done_d_r;

	adsc_sync #(.W(2)) u_sync (
		.clock (clock),
		.rst   (rst),
		.d     ({dev_done, pclk_stopped}),
		.q     ({done_s, stop_s})
	);

	adsc_timer #(.W(8)) u_settle (
		.clock (clock),
		.rst   (rst),
		.load  (timer_load),
		.count (8'(adsc_pkg::SETTLE_CYC)),
		.done  (timer_done)
	);
	assign timer_load = acc_done_r && state_r == adsc_pkg::S_ENA;

	// Device access for the current state
	always_comb begin
		acc_addr = adsc_pkg::DEV_IRQF;
		acc_data = 8'h00;
		acc_rd   = 1'b0;
		acc_any  = 1'b1;
		unique case (state_r)
			adsc_pkg::S_CLR, adsc_pkg::S_ACK: begin
				acc_addr = adsc_pkg::DEV_IRQF;
			end
			adsc_pkg::S_PCFG: begin
				acc_addr = adsc_pkg::DEV_PCFG;
				acc_data = {4'h0, pcfg};
			end
			adsc_pkg::S_DIR: begin
				acc_addr = adsc_pkg::DEV_P2DIR;
				acc_data = port_r[7:0] | chan_bit | (reduced ? adsc_pkg::P2_HIGH_PINS : 8'h00);
			end
			adsc_pkg::S_LAT: begin
				acc_addr = adsc_pkg::DEV_P2LAT;
				acc_data = port_r[15:8] & ~(reduced ? adsc_pkg::P2_HIGH_PINS : 8'h00);
			end
			adsc_pkg::S_ENA: begin
				acc_addr = adsc_pkg::DEV_MODE;
				acc_data = 8'h00;
				acc_data[adsc_pkg::MODE_TIME_LSB +: adsc_pkg::MODE_TIME_W] = ctime;
				acc_data[adsc_pkg::MODE_CE_BIT] = 1'b1;
			end
			adsc_pkg::S_CHAN: begin
				acc_addr = adsc_pkg::DEV_CHAN;
				acc_data = {5'h00, chan};
			end
			adsc_pkg::S_START: begin
				acc_addr = adsc_pkg::DEV_MODE;
				acc_data = 8'h00;
				acc_data[adsc_pkg::MODE_TIME_LSB +: adsc_pkg::MODE_TIME_W] = ctime;
				acc_data[adsc_pkg::MODE_CE_BIT] = !skip_ce;
				acc_data[adsc_pkg::MODE_START_BIT] = 1'b1;
			end
			adsc_pkg::S_RDL: begin
				acc_addr = adsc_pkg::DEV_RES_LO;
				acc_rd   = 1'b1;
			end
			adsc_pkg::S_RDH: begin
				acc_addr = adsc_pkg::DEV_RES_HI;
				acc_rd   = 1'b1;
			end
			adsc_pkg::S_STOP: begin
				acc_addr = adsc_pkg::DEV_MODE;
			end
			default: begin
				acc_any = 1'b0;
			end
		endcase
	end

	// Device bus engine: one access per state entry, held through wait cycles
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dev_addr   <= 3'h0;
			dev_wdata  <= 8'h00;
			dev_we     <= 1'b0;
			dev_re     <= 1'b0;
			go_r       <= 1'b0;
			acc_done_r <= 1'b0;
		end else begin
			acc_done_r <= (dev_we || dev_re) && !dev_wait;
			if (state_nxt != state_r) begin
				go_r <= 1'b1;
			end else if (go_r && acc_any && !stop_s) begin
				go_r      <= 1'b0;
				dev_addr  <= acc_addr;
				dev_wdata <= acc_data;
				dev_we    <= !acc_rd;
				dev_re    <= acc_rd;
			end else if (!dev_wait) begin
				dev_we <= 1'b0;
				dev_re <= 1'b0;
			end
		end
	end

	// Sequence
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			adsc_pkg::S_IDLE:
				if (start_cmd && !cfg_bad) state_nxt = adsc_pkg::S_CLR;
			adsc_pkg::S_CLR:
				if (acc_done_r) state_nxt = adsc_pkg::S_PCFG;
			adsc_pkg::S_PCFG:
				if (acc_done_r) state_nxt = adsc_pkg::S_DIR;
			adsc_pkg::S_DIR:
				if (acc_done_r) state_nxt = adsc_pkg::S_LAT;
			adsc_pkg::S_LAT:
				if (acc_done_r) state_nxt = skip_ce ? adsc_pkg::S_CHAN : adsc_pkg::S_ENA;
			adsc_pkg::S_ENA:
				if (acc_done_r) state_nxt = adsc_pkg::S_CHAN;
			adsc_pkg::S_CHAN:
				if (acc_done_r) state_nxt = skip_ce ? adsc_pkg::S_START : adsc_pkg::S_SETTLE;
			adsc_pkg::S_SETTLE:
				if (stop_req_r) state_nxt = adsc_pkg::S_STOP;
				else if (timer_done) state_nxt = adsc_pkg::S_START;
			adsc_pkg::S_START:
				if (acc_done_r) state_nxt = adsc_pkg::S_RUN;
			adsc_pkg::S_RUN:
				if (stop_req_r) state_nxt = adsc_pkg::S_STOP;
				else if (done_edge) state_nxt = adsc_pkg::S_RDL;
			adsc_pkg::S_RDL:
				if (acc_done_r) state_nxt = adsc_pkg::S_RDH;
			adsc_pkg::S_RDH:
				if (acc_done_r) state_nxt = adsc_pkg::S_ACK;
			adsc_pkg::S_ACK:
				if (acc_done_r) state_nxt = adsc_pkg::S_RUN;
			adsc_pkg::S_STOP:
				if (acc_done_r) state_nxt = adsc_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r  <= adsc_pkg::S_IDLE;
			done_d_r <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			done_d_r <= done_s;
		end
	end

	// Stop request is held until the sequence can act on it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stop_req_r <= 1'b0;
		end else if (state_nxt == adsc_pkg::S_STOP || state_r == adsc_pkg::S_IDLE) begin
			stop_req_r <= 1'b0;
		end else if (stop_cmd) begin
			stop_req_r <= 1'b1;
		end
	end

	// Result capture; first result after a start without enable is dropped
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			res_lo_r  <= 8'h00;
			result_r  <= 10'h000;
			discard_r <= 1'b0;
		end else begin
			if (state_r == adsc_pkg::S_START && acc_done_r) begin
				discard_r <= skip_ce;
			end
			if (acc_done_r && state_r == adsc_pkg::S_RDL) begin
				res_lo_r <= dev_rdata;
			end
			if (acc_done_r && state_r == adsc_pkg::S_RDH) begin
				discard_r <= 1'b0;
				if (!discard_r) begin
					result_r <= {dev_rdata[1:0], res_lo_r};
				end
			end
		end
	end

	always_comb begin
		irq_ev = '0;
		irq_ev[adsc_pkg::IRQ_RESULT]  = acc_done_r && state_r == adsc_pkg::S_RDH && !discard_r;
		irq_ev[adsc_pkg::IRQ_DROPPED] = acc_done_r && state_r == adsc_pkg::S_RDH && discard_r;
		irq_ev[adsc_pkg::IRQ_CFG_ERR] = start_cmd && state_r == adsc_pkg::S_IDLE && cfg_bad;
	end

	// Software registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_r    <= adsc_pkg::CFG_RESET;
			port_r   <= adsc_pkg::PORT_RESET;
			irq_mk_r <= '0;
		end else if (wr) begin
			if (addr == adsc_pkg::REG_CFG) cfg_r <= wdata;
			if (addr == adsc_pkg::REG_PORT) port_r <= wdata[15:0];
			if (addr == adsc_pkg::REG_IRQ_MK) irq_mk_r <= wdata[IRQ_W_L-1:0];
		end
	end

	// Sticky status: a new event wins over a write-one clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_st_r <= '0;
			irq      <= 1'b0;
		end else begin
			if (wr && addr == adsc_pkg::REG_IRQ_ST) begin
				irq_st_r <= (irq_st_r & ~wdata[IRQ_W_L-1:0]) | irq_ev;
			end else begin
				irq_st_r <= irq_st_r | irq_ev;
			end
			irq <= |(irq_st_r & irq_mk_r);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			unique case (addr)
				adsc_pkg::REG_CTRL:   rdata <= {31'h0, state_r != adsc_pkg::S_IDLE};
				adsc_pkg::REG_CFG:    rdata <= cfg_r;
				adsc_pkg::REG_PORT:   rdata <= {16'h0000, port_r};
				adsc_pkg::REG_STATUS: rdata <= {26'h0, discard_r, stop_s, 4'(state_r)};
				adsc_pkg::REG_RESULT: rdata <= {22'h0, result_r};
				adsc_pkg::REG_IRQ_ST: rdata <= {29'h0, irq_st_r};
				adsc_pkg::REG_IRQ_MK: rdata <= {29'h0, irq_mk_r};
				default:              rdata <= 32'h0000_0000;
			endcase
		end
	end

	// Cycles since the last comparator enable write, saturating
	logic [7:0] since_en_r;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			since_en_r <= 8'h00;
		end else if (dev_we && !dev_wait && dev_addr == adsc_pkg::DEV_MODE
			&& dev_wdata[adsc_pkg::MODE_CE_BIT] && !dev_wdata[adsc_pkg::MODE_START_BIT]) begin
			since_en_r <= 8'h00;
		end else if (since_en_r != 8'hFF) begin
			since_en_r <= since_en_r + 8'h01;
		end
	end

	a_chan_upper_zero: assert property (@(posedge clock) disable iff (rst)
		dev_we && dev_addr == adsc_pkg::DEV_CHAN |-> dev_wdata[7:3] == 5'h00)
		else $error("channel select upper bits not zero");
	a_chan_reduced: assert property (@(posedge clock) disable iff (rst)
		dev_we && dev_addr == adsc_pkg::DEV_CHAN && reduced |-> dev_wdata[2:1] != 2'b11)
		else $error("barred channel code written");
	a_pcfg_reduced: assert property (@(posedge clock) disable iff (rst)
		dev_we && dev_addr == adsc_pkg::DEV_PCFG && reduced
		|-> dev_wdata[3:0] != adsc_pkg::PCFG_BAD_A && dev_wdata[3:0] != adsc_pkg::PCFG_BAD_B)
		else $error("barred port configuration written");
	a_no_write_stopped: assert property (@(posedge clock) disable iff (rst)
		$rose(dev_we) |-> !$past(stop_s))
		else $error("write issued with peripheral clock stopped");
	a_dir_input: assert property (@(posedge clock) disable iff (rst)
		dev_we && dev_addr == adsc_pkg::DEV_P2DIR
		|-> (dev_wdata & chan_bit) != 8'h00 && (!reduced || dev_wdata[7:6] == 2'b11))
		else $error("channel pin not set as input");
	a_latch_clear: assert property (@(posedge clock) disable iff (rst)
		dev_we && dev_addr == adsc_pkg::DEV_P2LAT && reduced |-> dev_wdata[7:6] == 2'b00)
		else $error("port 2 latch bits 6 and 7 not cleared");
	a_settle_gap: assert property (@(posedge clock) disable iff (rst)
		$rose(dev_we) && dev_wdata[adsc_pkg::MODE_START_BIT] && dev_addr == adsc_pkg::DEV_MODE
		&& !skip_ce |-> since_en_r >= 8'(adsc_pkg::SETTLE_CYC))
		else $error("start set too soon after comparator enable");
	a_stop_clears: assert property (@(posedge clock) disable iff (rst)
		dev_we && state_r == adsc_pkg::S_STOP |-> dev_wdata == 8'h00 && dev_addr == adsc_pkg::DEV_MODE)
		else $error("stop did not clear start and enable");
	a_irq_level: assert property (@(posedge clock) disable iff (rst)
		##1 irq == |($past(irq_st_r) & $past(irq_mk_r)))
		else $error("interrupt output does not follow masked status");
endmodule

// ===== dv/adsc_dev_model.sv
// Behavioural converter device seen through its register port
`timescale 1ns/1ps
module adsc_dev_model (
	input  wire logic        clock,     // System clock
	input  wire logic        rst,       // Async reset
	input  wire logic [2:0]  dev_addr,  // Register select
	input  wire logic [7:0]  dev_wdata, // Write data
	input  wire logic        dev_we,    // Write strobe
	input  wire logic        dev_re,    // Read strobe
	output logic      [7:0]  dev_rdata, // Read data
	output logic             dev_wait,  // Wait cycle
	output logic             dev_done,  // Completion pin
	input  wire logic        reduced,   // Reduced-pin variant
	input  wire logic [9:0]  ain,       // Sampled level
	output logic      [7:0]  mode_q,    // Mode register
	output logic      [15:0] n_acc,     // Accepted accesses
	output logic      [7:0]  n_viol     // Host misuse count
);
	logic [7:0] reg_r [8];
	logic [7:0] rdq_r, cnt_r, age_r, len;
	logic       waited_r, rdv_r, bad_r, pseen_r, cseen_r;
	logic       acc, wacc, ctl_w, fin, start_w, ce_w, viol;
	logic [9:0] val;
	assign mode_q = reg_r[adsc_pkg::DEV_MODE];
	assign dev_done = reg_r[adsc_pkg::DEV_IRQF][0];
	// First cycle of a control write or result read is stretched
	assign dev_wait = !waited_r && ((dev_we && dev_addr <= adsc_pkg::DEV_PCFG) ||
		(dev_re && dev_addr inside {adsc_pkg::DEV_RES_LO, adsc_pkg::DEV_RES_HI}));
	assign acc = (dev_we || dev_re) && !dev_wait;
	assign wacc = dev_we && !dev_wait;
	assign ctl_w = wacc && dev_addr <= adsc_pkg::DEV_PCFG;
	assign fin = mode_q[7] && cnt_r == 8'h01;
	assign start_w = wacc && dev_addr == adsc_pkg::DEV_MODE && dev_wdata[7] && !mode_q[7];
	assign ce_w = wacc && dev_addr == adsc_pkg::DEV_MODE && dev_wdata[0] && !mode_q[0];
	assign len = 8'h28 + {1'b0, mode_q[5:1], 2'b00};
	assign val = bad_r ? ~ain : ain;
	// Released bus shows the inverse of the last value
	assign dev_rdata = rdv_r ? rdq_r : ~rdq_r;
	always_comb begin
		viol = 1'b0;
		if (wacc && dev_addr == adsc_pkg::DEV_CHAN) begin
			viol = dev_wdata[7:3] != 5'h00;
			viol |= reduced && dev_wdata[2:1] == 2'b11;
		end
		if (wacc && dev_addr == adsc_pkg::DEV_PCFG && reduced) begin
			viol = dev_wdata[3:0] == 4'h7 || dev_wdata[3:0] == 4'h8;
		end
		if (start_w) begin
			viol |= !reg_r[adsc_pkg::DEV_P2DIR][reg_r[adsc_pkg::DEV_CHAN][2:0]];
			viol |= reduced && reg_r[adsc_pkg::DEV_P2DIR][7:6] != 2'b11;
			viol |= reduced && reg_r[adsc_pkg::DEV_P2LAT][7:6] != 2'b00;
			viol |= dev_done;
			viol |= mode_q[0] && age_r < 8'h63;
		end
		if (ce_w) begin
			viol |= !pseen_r || cseen_r;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 8; i++) begin
				reg_r[i] <= 8'h00;
			end
		end else begin
			if (wacc && !(dev_addr inside {adsc_pkg::DEV_RES_LO, adsc_pkg::DEV_RES_HI})) begin
				reg_r[dev_addr] <= dev_wdata;
			end
			// Mode, channel or port configuration write at conversion end wins; other writes leave the flag
			if (fin && !ctl_w) begin
				reg_r[adsc_pkg::DEV_RES_LO] <= val[7:0];
				reg_r[adsc_pkg::DEV_RES_HI] <= {6'h00, val[9:8]};
				reg_r[adsc_pkg::DEV_IRQF][0] <= 1'b1;
			end
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			waited_r <= 1'b0;
			rdv_r <= 1'b0;
			rdq_r <= 8'h00;
			n_acc <= 16'h0000;
			n_viol <= 8'h00;
		end else begin
			waited_r <= dev_wait;
			rdv_r <= acc && dev_re;
			if (acc && dev_re) begin
				rdq_r <= reg_r[dev_addr];
			end
			n_acc <= n_acc + 16'(acc);
			n_viol <= n_viol + 8'(viol);
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_r <= 8'h00;
			age_r <= 8'h00;
			bad_r <= 1'b0;
			pseen_r <= 1'b0;
			cseen_r <= 1'b0;
		end else begin
			age_r <= !mode_q[0] ? 8'h00 : (age_r == 8'hFF ? age_r : age_r + 8'h01);
			if (start_w) begin
				cnt_r <= len;
				bad_r <= !dev_wdata[0] || !mode_q[0] || age_r < 8'h63;
			end else if (fin) begin
				cnt_r <= len;
				bad_r <= 1'b0;
			end else if (cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
			end
			if (wacc && dev_addr == adsc_pkg::DEV_PCFG) begin
				pseen_r <= 1'b1;
			end
			if (wacc && dev_addr == adsc_pkg::DEV_CHAN) begin
				cseen_r <= 1'b1;
			end
			if (wacc && dev_addr == adsc_pkg::DEV_MODE && dev_wdata == 8'h00) begin
				pseen_r <= 1'b0;
				cseen_r <= 1'b0;
			end
		end
	end
endmodule

// ===== dv/tb_adsc_ctrl.sv
// Self-checking bench for the converter sequencing controller
`timescale 1ns/1ps
module tb_adsc_ctrl;
	logic        clock, rst, wr, rd, pclk_stopped, reduced, irq;
	logic        dev_we, dev_re, dev_wait, dev_done;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, rv;
	logic [2:0]  dev_addr;
	logic [7:0]  dev_wdata, dev_rdata, mode_q, n_viol;
	logic [9:0]  ain;
	logic [15:0] n_acc, acc0;
	int          n_fail, check_count;
	adsc_ctrl u_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_we(dev_we),
		.dev_re(dev_re), .dev_rdata(dev_rdata), .dev_wait(dev_wait), .dev_done(dev_done),
		.pclk_stopped(pclk_stopped));
	adsc_dev_model u_dev (.clock(clock), .rst(rst), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .dev_we(dev_we), .dev_re(dev_re), .dev_rdata(dev_rdata),
		.dev_wait(dev_wait), .dev_done(dev_done), .reduced(reduced), .ain(ain),
		.mode_q(mode_q), .n_acc(n_acc), .n_viol(n_viol));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] cfg(input logic [2:0] ch, input logic [3:0] pc,
		input logic [4:0] tm, input logic red, input logic skip);
		return {18'h0, skip, red, tm, pc, ch};
	endfunction
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [31:0] exp);
		rd_reg(a, rv);
		chk(rv, exp);
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && irq !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		chk({31'h0, irq}, 32'h0000_0001);
	endtask
	task automatic go(input logic [31:0] c);
		wr_reg(adsc_pkg::REG_CFG, c);
		wr_reg(adsc_pkg::REG_CTRL, 32'h0000_0001);
	endtask
	task automatic halt;
		wr_reg(adsc_pkg::REG_CTRL, 32'h0000_0002);
		repeat (40) @(posedge clock);
		wr_reg(adsc_pkg::REG_IRQ_ST, 32'h0000_0007);
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#400_000;
		n_fail++;
		wrap_up();
	end
	initial begin
		rst = 1'b1;
		{wr, rd, pclk_stopped, reduced} = 4'h0;
		addr = 4'h0;
		wdata = 32'h0000_0000;
		ain = 10'h2A5;
		n_fail = 0;
		check_count = 0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		chk_rd(adsc_pkg::REG_CFG, adsc_pkg::CFG_RESET);
		chk_rd(adsc_pkg::REG_PORT, {16'h0000, adsc_pkg::PORT_RESET});
		chk_rd(adsc_pkg::REG_IRQ_MK, 32'h0000_0000);
		chk_rd(4'hA, 32'h0000_0000);
		wr_reg(adsc_pkg::REG_IRQ_MK, 32'h0000_0001);
		go(cfg(3'h2, 4'h4, 5'h1F, 1'b0, 1'b0));
		wait_irq(3000);
		chk_rd(adsc_pkg::REG_RESULT, {22'h0, ain});
		chk_rd(adsc_pkg::REG_IRQ_ST, 32'h0000_0001);
		wr_reg(adsc_pkg::REG_IRQ_ST, 32'h0000_0001);
		repeat (2) @(posedge clock);
		#1;
		chk({31'h0, irq}, 32'h0000_0000);
		halt();
		chk({24'h0, mode_q}, 32'h0000_0000);
		chk_rd(adsc_pkg::REG_CTRL, 32'h0000_0000);
		// Barred codes on the reduced-pin variant
		reduced <= 1'b1;
		wr_reg(adsc_pkg::REG_IRQ_MK, 32'h0000_0002);
		for (int k = 0; k < 4; k++) begin
			go(k < 2 ? cfg(3'(6 + k), 4'h4, 5'h00, 1'b1, 1'b0) :
				cfg(3'h1, 4'(5 + k), 5'h00, 1'b1, 1'b0));
			wait_irq(500);
			chk_rd(adsc_pkg::REG_IRQ_ST, 32'h0000_0002);
			halt();
		end
		wr_reg(adsc_pkg::REG_PORT, 32'h0000_C000);
		wr_reg(adsc_pkg::REG_IRQ_MK, 32'h0000_0001);
		go(cfg(3'h1, 4'h4, 5'h02, 1'b1, 1'b0));
		wait_irq(3000);
		chk_rd(adsc_pkg::REG_RESULT, {22'h0, ain});
		halt();
		// Comparator enable skipped: first result is bad and must be dropped
		reduced <= 1'b0;
		ain <= 10'h155;
		go(cfg(3'h3, 4'h4, 5'h01, 1'b0, 1'b1));
		wait_irq(3000);
		chk_rd(adsc_pkg::REG_RESULT, 32'h0000_0155);
		chk_rd(adsc_pkg::REG_IRQ_ST, 32'h0000_0005);
		halt();
		pclk_stopped <= 1'b1;
		repeat (5) @(posedge clock);
		acc0 = n_acc;
		go(cfg(3'h5, 4'h6, 5'h01, 1'b0, 1'b0));
		repeat (200) @(posedge clock);
		chk({16'h0000, n_acc}, {16'h0000, acc0});
		chk_rd(adsc_pkg::REG_STATUS, 32'h0000_0010 | 32'(adsc_pkg::S_CLR));
		pclk_stopped <= 1'b0;
		wr_reg(adsc_pkg::REG_IRQ_MK, 32'h0000_0000);
		repeat (1500) @(posedge clock);
		chk({31'h0, irq}, 32'h0000_0000);
		rd_reg(adsc_pkg::REG_IRQ_ST, rv);
		chk({31'h0, rv[0]}, 32'h0000_0001);
		wr_reg(adsc_pkg::REG_IRQ_MK, 32'h0000_0001);
		repeat (2) @(posedge clock);
		#1;
		chk({31'h0, irq}, 32'h0000_0001);
		halt();
		chk({24'h0, n_viol}, 32'h0000_0000);
		wrap_up();
	end
endmodule
